/* src/cpfs_pkg.sv */
// shared constants for the clock output pin function select block
package cpfs_pkg;

   // clock and shift timing
   localparam int CLK_PERIOD_NS   = 50;
   localparam int SHIFT_HALF_NS   = 500;
   localparam int SHIFT_HALF_CYC  = (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // shared pin indices
   localparam int NUM_PINS        = 5;
   localparam int PIN_P11_TRUE    = 0;
   localparam int PIN_P7_COMP     = 1;
   localparam int PIN_P7_TRUE     = 2;
   localparam int PIN_CPU_STOP    = 3;
   localparam int PIN_PCI_STOP    = 4;

   // configuration byte 3: output pair enables
   localparam int B3_P11_EN       = 7;
   localparam int B3_P7_EN        = 3;
   // configuration byte 6: clock request selects
   localparam int B6_CR_H         = 4;
   localparam int B6_CR_E         = 7;
   localparam int B6_CR_F         = 6;
   localparam logic [7:0] CFG3_RESET = 8'hff;
   localparam logic [7:0] CFG6_RESET = 8'h00;

   // frequency select
   localparam int FS_BITS         = 3;
   localparam logic [2:0] FS_RESET = 3'h0;

   // controller register map
   localparam int REG_AW          = 4;
   localparam int REG_DW          = 8;
   localparam logic [3:0] REG_CFG3   = 4'h0;
   localparam logic [3:0] REG_CFG6   = 4'h1;
   localparam logic [3:0] REG_CTRL   = 4'h2;
   localparam logic [3:0] REG_FS     = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;

   // control register fields
   localparam int CTRL_PWRGD      = 0;
   localparam int CTRL_STRAP5     = 1;
   localparam int CTRL_STRAP_DBG  = 2;
   localparam int CTRL_CPU_STOP_N = 3;
   localparam int CTRL_PCI_STOP_N = 4;
   localparam int CTRL_CR_H_N     = 5;
   localparam int CTRL_CR_E_N     = 6;
   localparam int CTRL_CR_F_N     = 7;
   localparam logic [7:0] CTRL_RESET = 8'hf8;

endpackage : cpfs_pkg

/* src/cpfs_if.sv */
// pins, straps and configuration joining controller and clock device
interface cpfs_if;
   logic [cpfs_pkg::NUM_PINS-1:0] dev_o;
   logic [cpfs_pkg::NUM_PINS-1:0] dev_oe;
   logic [cpfs_pkg::NUM_PINS-1:0] host_o;
   logic [cpfs_pkg::NUM_PINS-1:0] host_oe;
   logic [cpfs_pkg::NUM_PINS-1:0] pin;
   logic                          power_good_powerdown_n;
   logic                          stop_or_pair5_strap;
   logic                          debug_port_enable_strap;
   logic [7:0]                    cfg_byte3;
   logic [7:0]                    cfg_byte6;

   // resolved wire level, pulled high when nobody drives
   genvar gi;
   for (gi = 0; gi < cpfs_pkg::NUM_PINS; gi++)
   begin : g_res
      assign pin[gi] = dev_oe[gi] ? dev_o[gi] : (host_oe[gi] ? host_o[gi] : 1'b1);
   end

   modport device (
      output dev_o, dev_oe,
      input  pin, power_good_powerdown_n, stop_or_pair5_strap,
      input  debug_port_enable_strap, cfg_byte3, cfg_byte6
   );
   modport host (
      output host_o, host_oe, power_good_powerdown_n, stop_or_pair5_strap,
      output debug_port_enable_strap, cfg_byte3, cfg_byte6,
      input  pin
   );
endinterface : cpfs_if

/* src/cpfs_host.sv */
// controller end: register port, straps, stop and request pins, serial shifter
module cpfs_host (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic [cpfs_pkg::REG_AW-1:0] addr,
   input  wire logic [cpfs_pkg::REG_DW-1:0] wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output      logic [cpfs_pkg::REG_DW-1:0] rdata,
   cpfs_if.host                            link
);

   typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} cpfs_sh_t;

   typedef struct packed {
      logic [7:0] cfg3;
      logic [7:0] cfg6;
      logic [7:0] ctrl;
      cpfs_sh_t   sh;
      logic [2:0] sr;
      logic [1:0] nbit;
      logic [7:0] tmr;
      logic [7:0] rdata;
   } cpfs_host_st_t;

   cpfs_host_st_t st;
   cpfs_host_st_t next_st;

   // clear request selects whose shared pair is still enabled
   function automatic logic [7:0] cpfs_safe6(input logic [7:0] b6, input logic [7:0] b3);
      logic [7:0] r;
      r = b6;
      if (b3[cpfs_pkg::B3_P11_EN])
         r[cpfs_pkg::B6_CR_H] = 1'b0;
      if (b3[cpfs_pkg::B3_P7_EN])
      begin
         r[cpfs_pkg::B6_CR_E] = 1'b0;
         r[cpfs_pkg::B6_CR_F] = 1'b0;
      end
      return r;
   endfunction

   always_comb
   begin
      next_st = st;
      next_st.rdata = '0;
      if (wr)
      begin
         case (addr)
            cpfs_pkg::REG_CFG3:
            begin
               next_st.cfg3 = wdata;
               next_st.cfg6 = cpfs_safe6(st.cfg6, wdata);
            end
            cpfs_pkg::REG_CFG6: next_st.cfg6 = cpfs_safe6(wdata, st.cfg3);
            cpfs_pkg::REG_CTRL: next_st.ctrl = wdata;
            cpfs_pkg::REG_FS:
            begin
               if (st.sh == SH_IDLE)
               begin
                  next_st.sr   = wdata[2:0];
                  next_st.nbit = 2'd0;
                  next_st.tmr  = 8'h00;
                  next_st.sh   = SH_LOW;
               end
            end
            default: ;
         endcase
      end
      if (rd)
      begin
         case (addr)
            cpfs_pkg::REG_CFG3:   next_st.rdata = st.cfg3;
            cpfs_pkg::REG_CFG6:   next_st.rdata = st.cfg6;
            cpfs_pkg::REG_CTRL:   next_st.rdata = st.ctrl;
            cpfs_pkg::REG_STATUS: next_st.rdata = {2'b00, link.pin, st.sh != SH_IDLE};
            default:              next_st.rdata = '0;
         endcase
      end
      // shift c, b, a msb first, one shift clock per bit
      case (st.sh)
         SH_IDLE: ;
         SH_LOW:
         begin
            next_st.tmr = st.tmr + 8'h01;
            if (st.tmr == 8'(cpfs_pkg::SHIFT_HALF_CYC - 1))
            begin
               next_st.tmr = 8'h00;
               next_st.sh  = SH_HIGH;
            end
         end
         SH_HIGH:
         begin
            next_st.tmr = st.tmr + 8'h01;
            if (st.tmr == 8'(cpfs_pkg::SHIFT_HALF_CYC - 1))
            begin
               next_st.tmr  = 8'h00;
               next_st.sr   = {st.sr[1:0], 1'b0};
               next_st.nbit = st.nbit + 2'd1;
               next_st.sh   = (st.nbit == 2'd2) ? SH_IDLE : SH_LOW;
            end
         end
         default: next_st.sh = SH_IDLE;
      endcase
      if (rst)
      begin
         next_st       = '0;
         next_st.cfg3  = cpfs_pkg::CFG3_RESET;
         next_st.cfg6  = cpfs_pkg::CFG6_RESET;
         next_st.ctrl  = cpfs_pkg::CTRL_RESET;
         next_st.sh    = SH_IDLE;
      end
   end

   always_ff @(posedge core_clk)
   begin
      st <= next_st;
   end

   assign rdata = st.rdata;
   assign link.cfg_byte3 = st.cfg3;
   assign link.cfg_byte6 = st.cfg6;
   assign link.power_good_powerdown_n  = st.ctrl[cpfs_pkg::CTRL_PWRGD];
   assign link.stop_or_pair5_strap     = st.ctrl[cpfs_pkg::CTRL_STRAP5];
   assign link.debug_port_enable_strap = st.ctrl[cpfs_pkg::CTRL_STRAP_DBG];

   // request pins driven only once the device has released them
   assign link.host_o[cpfs_pkg::PIN_P11_TRUE]  = st.ctrl[cpfs_pkg::CTRL_CR_H_N];
   assign link.host_oe[cpfs_pkg::PIN_P11_TRUE] = st.cfg6[cpfs_pkg::B6_CR_H];
   assign link.host_o[cpfs_pkg::PIN_P7_COMP]   = st.ctrl[cpfs_pkg::CTRL_CR_E_N];
   assign link.host_oe[cpfs_pkg::PIN_P7_COMP]  = st.cfg6[cpfs_pkg::B6_CR_E];
   assign link.host_o[cpfs_pkg::PIN_P7_TRUE]   = st.ctrl[cpfs_pkg::CTRL_CR_F_N];
   assign link.host_oe[cpfs_pkg::PIN_P7_TRUE]  = st.cfg6[cpfs_pkg::B6_CR_F];

   // stop pins double as shift data and shift clock
   assign link.host_o[cpfs_pkg::PIN_CPU_STOP]  = (st.sh != SH_IDLE) ? st.sr[2] :
                                                 st.ctrl[cpfs_pkg::CTRL_CPU_STOP_N];
   assign link.host_o[cpfs_pkg::PIN_PCI_STOP]  = (st.sh != SH_IDLE) ? (st.sh == SH_HIGH) :
                                                 st.ctrl[cpfs_pkg::CTRL_PCI_STOP_N];
   assign link.host_oe[cpfs_pkg::PIN_CPU_STOP] = ~st.ctrl[cpfs_pkg::CTRL_STRAP5];
   assign link.host_oe[cpfs_pkg::PIN_PCI_STOP] = ~st.ctrl[cpfs_pkg::CTRL_STRAP5];

endmodule // cpfs_host

/* src/cpfs_device.sv */
// clock device end: strap latch, shared pin roles, stops, requests, fs shift
//
// Function
// - pin 11 true default; byte6 bit4 request H
// - host disables pair 11 before request use
// - disabled pair goes high impedance, then request
// - pin 7 complement default; byte6 bit7 request E
// - pin 7 true default; byte6 bit6 request F
// - host disables pair 7 before request use
// - strap picks stop inputs or pair 5
// - cpu stop halts non free cpu clocks
// - pci stop halts non free pci clocks
// - management mode shifts three fs bits in
// - pci stop pin is shift clock then
// - debug strap picks pair 8 or debug
// - power good samples straps, marks modes
module cpfs_device #(
   parameter int              NUM_CPU  = 2,
   parameter int              NUM_PCI  = 6,
   parameter logic [1:0]      CPU_FREE = 2'h2,
   parameter logic [5:0]      PCI_FREE = 6'h20
) (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               ref_clk_level,
   output      logic [NUM_CPU-1:0] cpu_run,
   output      logic [NUM_PCI-1:0] pci_run,
   output      logic               pair5_run,
   output      logic               pair6_run,
   output      logic               pair8_run,
   output      logic               pair10_run,
   output      logic               pair11_run,
   output      logic               pair7_run,
   output      logic               debug_port_run,
   output      logic [2:0]         freq_select,
   output      logic               straps_latched,
   output      logic               mgmt_mode,
   cpfs_if.device                  link
);

   typedef struct packed {
      // strap latch
      logic                latched;
      logic                strap5;
      logic                strap_dbg;
      // edge history and serial capture
      logic                pg_q;
      logic                sck_q;
      logic [1:0]          cnt;
      logic [1:0]          sr;
      logic [2:0]          fs;
      // registered pin and pair levels
      logic [4:0]          pin_o;
      logic [NUM_CPU-1:0]  cpu;
      logic [NUM_PCI-1:0]  pci;
      logic                p5;
      logic                p6;
      logic                p7;
      logic                p8;
      logic                p10;
      logic                p11;
      logic                dbg;
   } cpfs_dev_st_t;

   cpfs_dev_st_t st;
   cpfs_dev_st_t next_st;

   logic pg;
   logic pwr;
   logic mgmt;
   logic p11_en;
   logic p7_en;
   logic cr_h_act;
   logic cr_e_act;
   logic cr_f_act;
   logic cpu_stop;
   logic pci_stop;
   logic sck_rise;
   logic drv_h;
   logic drv_e;
   logic drv_f;

   // request acts only with its select set and its pair disabled
   function automatic logic cpfs_req_act(input logic sel, input logic pair_en);
      return sel & ~pair_en;
   endfunction

   // governed pair runs while its request is low
   function automatic logic cpfs_gate(input logic act, input logic req_n);
      return ~act | ~req_n;
   endfunction

   // pin keeps its output role while its pair is enabled and unselected
   function automatic logic cpfs_drv(input logic pair_en, input logic sel);
      return pair_en & ~sel;
   endfunction

   always_comb
   begin
      pg       = link.power_good_powerdown_n;
      pwr      = st.latched & pg;
      mgmt     = st.latched & ~pg & ~st.strap5;
      p11_en   = link.cfg_byte3[cpfs_pkg::B3_P11_EN];
      p7_en    = link.cfg_byte3[cpfs_pkg::B3_P7_EN];
      cr_h_act = cpfs_req_act(link.cfg_byte6[cpfs_pkg::B6_CR_H], p11_en);
      cr_e_act = cpfs_req_act(link.cfg_byte6[cpfs_pkg::B6_CR_E], p7_en);
      cr_f_act = cpfs_req_act(link.cfg_byte6[cpfs_pkg::B6_CR_F], p7_en);
      cpu_stop = pwr & ~st.strap5 & ~link.pin[cpfs_pkg::PIN_CPU_STOP];
      pci_stop = pwr & ~st.strap5 & ~link.pin[cpfs_pkg::PIN_PCI_STOP];
      sck_rise = mgmt & link.pin[cpfs_pkg::PIN_PCI_STOP] & ~st.sck_q;
      drv_h    = cpfs_drv(p11_en, link.cfg_byte6[cpfs_pkg::B6_CR_H]);
      drv_e    = cpfs_drv(p7_en, link.cfg_byte6[cpfs_pkg::B6_CR_E]);
      drv_f    = cpfs_drv(p7_en, link.cfg_byte6[cpfs_pkg::B6_CR_F]);
   end

   always_comb
   begin
      next_st = st;
      next_st.pg_q  = pg;
      next_st.sck_q = link.pin[cpfs_pkg::PIN_PCI_STOP];

      // straps caught on the first rise of power good
      if (!st.latched && pg && !st.pg_q)
      begin
         next_st.latched   = 1'b1;
         next_st.strap5    = link.stop_or_pair5_strap;
         next_st.strap_dbg = link.debug_port_enable_strap;
      end

      // serial frequency select capture
      if (!mgmt)
      begin
         next_st.cnt = 2'd0;
      end
      else if (sck_rise)
      begin
         if (st.cnt == 2'd2)
         begin
            next_st.fs  = {st.sr, link.pin[cpfs_pkg::PIN_CPU_STOP]};
            next_st.cnt = 2'd0;
         end
         else
         begin
            next_st.sr  = {st.sr[0], link.pin[cpfs_pkg::PIN_CPU_STOP]};
            next_st.cnt = st.cnt + 2'd1;
         end
      end

      // shared pin output levels
      next_st.pin_o[cpfs_pkg::PIN_P11_TRUE] = pwr & ref_clk_level;
      next_st.pin_o[cpfs_pkg::PIN_P7_COMP]  = pwr & ~ref_clk_level;
      next_st.pin_o[cpfs_pkg::PIN_P7_TRUE]  = pwr & ref_clk_level;
      next_st.pin_o[cpfs_pkg::PIN_CPU_STOP] = pwr & ~ref_clk_level;
      next_st.pin_o[cpfs_pkg::PIN_PCI_STOP] = pwr & ref_clk_level;

      // pair run levels
      next_st.cpu = {NUM_CPU{pwr}} & ~({NUM_CPU{cpu_stop}} & ~CPU_FREE);
      next_st.pci = {NUM_PCI{pwr}} & ~({NUM_PCI{pci_stop}} & ~PCI_FREE);
      next_st.p5  = pwr & st.strap5;
      next_st.p11 = pwr & drv_h;
      next_st.p7  = pwr & drv_e & drv_f;
      next_st.p10 = pwr & cpfs_gate(cr_h_act, link.pin[cpfs_pkg::PIN_P11_TRUE]);
      next_st.p6  = pwr & cpfs_gate(cr_e_act, link.pin[cpfs_pkg::PIN_P7_COMP]);
      next_st.p8  = pwr & ~st.strap_dbg
                    & cpfs_gate(cr_f_act, link.pin[cpfs_pkg::PIN_P7_TRUE]);
      next_st.dbg = pwr & st.strap_dbg;

      // synchronous reset overrides all
      if (rst)
      begin
         next_st       = '0;
         next_st.sck_q = 1'b1;
         next_st.fs    = cpfs_pkg::FS_RESET;
      end
   end

   // one register stage for all state
   always_ff @(posedge core_clk)
   begin
      st <= next_st;
   end

   // shared pin drivers
   always_comb
   begin
      link.dev_o  = st.pin_o;
      link.dev_oe = '0;
      link.dev_oe[cpfs_pkg::PIN_P11_TRUE] = drv_h;
      link.dev_oe[cpfs_pkg::PIN_P7_COMP]  = drv_e;
      link.dev_oe[cpfs_pkg::PIN_P7_TRUE]  = drv_f;
      link.dev_oe[cpfs_pkg::PIN_CPU_STOP] = st.latched & st.strap5;
      link.dev_oe[cpfs_pkg::PIN_PCI_STOP] = st.latched & st.strap5;
   end

   assign cpu_run        = st.cpu;
   assign pci_run        = st.pci;
   assign pair5_run      = st.p5;
   assign pair6_run      = st.p6;
   assign pair7_run      = st.p7;
   assign pair8_run      = st.p8;
   assign pair10_run     = st.p10;
   assign pair11_run     = st.p11;
   assign debug_port_run = st.dbg;
   assign freq_select    = st.fs;
   assign straps_latched = st.latched;
   assign mgmt_mode      = mgmt;

endmodule // cpfs_device

/* testbench/cpfs_chk.sv */
// concurrent checks on the shared pins, straps and device outputs
module cpfs_chk (
   input wire logic                          core_clk,
   input wire logic                          rst,
   input wire logic [cpfs_pkg::NUM_PINS-1:0] dev_oe,
   input wire logic [cpfs_pkg::NUM_PINS-1:0] pin,
   input wire logic                          power_good_powerdown_n,
   input wire logic                          stop_or_pair5_strap,
   input wire logic [7:0]                    cfg_byte3,
   input wire logic [7:0]                    cfg_byte6,
   input wire logic [1:0]                    cpu_run,
   input wire logic [5:0]                    pci_run,
   input wire logic                          pair10_run,
   input wire logic [2:0]                    freq_select,
   input wire logic                          straps_latched,
   input wire logic                          mgmt_mode
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // strap value the device keeps, caught while not yet latched
   logic strap5_q;
   always_ff @(posedge core_clk)
   begin
      if (rst)
         strap5_q <= 1'b0;
      else if (!straps_latched)
         strap5_q <= stop_or_pair5_strap;
   end

   // powered, latched, stop-pin role
   sequence s_up;
      power_good_powerdown_n && straps_latched && !strap5_q;
   endsequence
   sequence s_h_role;
      cfg_byte6[4] && !cfg_byte3[7];
   endsequence

   a_pair11_drive: assert property (dev_oe[0] == cfg_byte3[7])
      else $error("pair 11 pin drive does not follow its enable");
   a_pair7_drive: assert property (dev_oe[2:1] == {2{cfg_byte3[3]}})
      else $error("pair 7 pins drive does not follow their enable");
   a_h_needs_off: assert property (cfg_byte3[7] && $past(cfg_byte3[7]) |-> !cfg_byte6[4])
      else $error("request h selected while pair 11 enabled");
   a_ef_need_off: assert property (cfg_byte3[3] |-> cfg_byte6[7:6] == 2'h0)
      else $error("request e or f selected while pair 7 enabled");
   a_req_h_gate: assert property (s_up ##0 s_h_role |=> pair10_run == !$past(pin[0]))
      else $error("pair 10 does not follow request h");
   a_cpu_stop: assert property (s_up ##0 !pin[3] |=> cpu_run == 2'h2)
      else $error("cpu clocks not stopped");
   a_pci_stop: assert property (s_up ##0 !pin[4] |=> pci_run == 6'h20)
      else $error("pci clocks not stopped");
   a_stop_pins_in: assert property (s_up |-> dev_oe[4:3] == 2'h0)
      else $error("stop pins driven by device");
   a_fs_in_mgmt: assert property (!$stable(freq_select) |-> $past(mgmt_mode))
      else $error("frequency select changed outside management mode");
   a_latch_cause: assert property ($rose(straps_latched) |-> $past(power_good_powerdown_n))
      else $error("straps latched without power good");
   a_latch_hold: assert property (straps_latched |=> straps_latched)
      else $error("strap latch lost");
endmodule // cpfs_chk

/* testbench/tb_top.sv */
// self-checking bench joining controller and clock device
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       ref_clk_level = 1'b0;
   logic [1:0] cpu_run;
   logic [5:0] pci_run;
   logic       pair5_run, pair6_run, pair7_run, pair8_run, pair10_run, pair11_run;
   logic       debug_port_run, straps_latched, mgmt_mode;
   logic [2:0] freq_select;
   logic [7:0] exp_q[$];
   logic       prev_rd = 1'b0;
   logic [7:0] lfsr = 8'h51;
   int         num_errors = 0;
   int         n_checks = 0;

   cpfs_if link ();
   cpfs_host i_cpfs_host (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .link(link));
   cpfs_device i_cpfs_device (.core_clk(core_clk), .rst(rst), .ref_clk_level(ref_clk_level),
      .cpu_run(cpu_run), .pci_run(pci_run), .pair5_run(pair5_run), .pair6_run(pair6_run),
      .pair8_run(pair8_run), .pair10_run(pair10_run), .pair11_run(pair11_run),
      .pair7_run(pair7_run), .debug_port_run(debug_port_run), .freq_select(freq_select),
      .straps_latched(straps_latched), .mgmt_mode(mgmt_mode), .link(link));
   cpfs_chk u_chk (.core_clk(core_clk), .rst(rst), .dev_oe(link.dev_oe), .pin(link.pin),
      .power_good_powerdown_n(link.power_good_powerdown_n),
      .stop_or_pair5_strap(link.stop_or_pair5_strap), .cfg_byte3(link.cfg_byte3),
      .cfg_byte6(link.cfg_byte6), .cpu_run(cpu_run), .pci_run(pci_run),
      .pair10_run(pair10_run), .freq_select(freq_select), .straps_latched(straps_latched),
      .mgmt_mode(mgmt_mode));

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) ref_clk_level <= ~ref_clk_level;

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // read data compared in the cycle after the strobe
   always @(negedge core_clk)
   begin
      if (prev_rd)
         check("rdata", rdata, exp_q.pop_front());
      prev_rd = rd;
   end

   initial
   begin
      repeat (3000) @(posedge core_clk);
      num_errors++;
      test_done();
   end

   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      wr_reg(4'hf, 8'h5a);
      wr_reg(cpfs_pkg::REG_CFG6, 8'hd0);
      rd_chk(cpfs_pkg::REG_CFG3, cpfs_pkg::CFG3_RESET);
      rd_chk(cpfs_pkg::REG_CFG6, 8'h00);
      rd_chk(cpfs_pkg::REG_CTRL, cpfs_pkg::CTRL_RESET);
      wr_reg(cpfs_pkg::REG_CTRL, 8'hf9);
      settle(4);
      check("latched", straps_latched, 8'h01);
      check("pair5", pair5_run, 8'h00);
      check("pair8", {debug_port_run, pair8_run}, 8'h01);
      check("pair11_7", {pair11_run, pair7_run}, 8'h03);
      $display("test straps done");
      for (int i = 0; i < 2; i++)
      begin
         wr_reg(cpfs_pkg::REG_CTRL, i ? 8'he9 : 8'hf1);
         settle(4);
         check("cpu", cpu_run, i ? 8'h03 : 8'h02);
         check("pci", pci_run, i ? 8'h20 : 8'h3f);
      end
      $display("test stops done");
      wr_reg(cpfs_pkg::REG_CFG3, 8'h77);
      wr_reg(cpfs_pkg::REG_CFG6, 8'hd0);
      rd_chk(cpfs_pkg::REG_CFG6, 8'hd0);
      repeat (8)
      begin
         lfsr = lfsr_next(lfsr);
         wr_reg(cpfs_pkg::REG_CTRL, {lfsr[2:0], 5'h19});
         settle(4);
         check("req", {pair8_run, pair6_run, pair10_run}, {5'h0, ~lfsr[2:0]});
      end
      check("oe", link.dev_oe[2:0], 8'h00);
      check("p11_7_off", {pair11_run, pair7_run}, 8'h00);
      wr_reg(cpfs_pkg::REG_CFG3, 8'hff);
      rd_chk(cpfs_pkg::REG_CFG6, 8'h00);
      $display("test requests done");
      wr_reg(cpfs_pkg::REG_CTRL, 8'hf8);
      settle(2);
      check("mgmt", mgmt_mode, 8'h01);
      rd_chk(cpfs_pkg::REG_STATUS, 8'h30);
      for (int i = 0; i < 3; i++)
      begin
         lfsr = lfsr_next(lfsr);
         wr_reg(cpfs_pkg::REG_FS, {5'h0, lfsr[2:0]});
         settle(70);
         check("fs", freq_select, {5'h0, lfsr[2:0]});
      end
      wr_reg(cpfs_pkg::REG_CTRL, 8'hf9);
      settle(4);
      check("fs_keep", freq_select, {5'h0, lfsr[2:0]});
      $display("test shift done");
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      wr_reg(cpfs_pkg::REG_CTRL, 8'hff);
      settle(4);
      check("pair5_dbg", {debug_port_run, pair8_run, pair5_run}, 8'h05);
      check("oe_5", link.dev_oe[4:3], 8'h03);
      wr_reg(cpfs_pkg::REG_CTRL, 8'hf9);
      settle(4);
      check("strap_keep", {debug_port_run, pair5_run}, 8'h03);
      $display("test second strap done");
      test_done();
   end
endmodule // tb_top
